// [src/gpset_cfg.svh]
`ifndef GPSET_CFG_SVH
`define GPSET_CFG_SVH
// Function
// - writing 1 to a set bit forces that output data bit high
// - writing 0 to a set bit leaves that output data bit unchanged
// - reading the set address returns the live output data value
// - set bit n touches only output data bit n, bits 7 to 0
// - output data drives pin only in gpio mode with driver enabled

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define GPSET_ADDR_W 12
`define GPSET_DATA_W 8

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define GPSET_IDX_VALUE 10'h04a
`define GPSET_IDX_SET 10'h04b
`define GPSET_IDX_OEN 10'h050
`define GPSET_IDX_MODE 10'h051

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GPSET_RST_VALUE 8'h00
`define GPSET_RST_OEN 8'h00
`define GPSET_RST_MODE 8'h00

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define GPSET_RESP_OKAY 2'h0
`define GPSET_RESP_SLVERR 2'h2

`endif

// [src/gpset_pkg.sv]
`include "gpset_cfg.svh"

package gpset_pkg;

   // register selected by an address
   typedef enum logic [2:0] {
      GPSET_SEL_NONE = 3'b000,
      GPSET_SEL_VALUE = 3'b001,
      GPSET_SEL_SET = 3'b010,
      GPSET_SEL_OEN = 3'b011,
      GPSET_SEL_MODE = 3'b100
   } gpset_sel_t;

   // write channel state
   typedef enum logic {
      GPSET_WS_COLLECT = 1'b0,
      GPSET_WS_RESP = 1'b1
   } gpset_wstate_t;

   // command into the output data register
   typedef struct packed {
      logic load;
      logic set;
      logic [`GPSET_DATA_W-1:0] bits;
   } gpset_dcmd_t;

endpackage

// [src/gpset_datareg.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpset_cfg.svh"

module gpset_datareg (
   input wire logic mclk,
   input wire logic rst,
   input wire gpset_pkg::gpset_dcmd_t cmd,
   output logic [`GPSET_DATA_W-1:0] value
);

   // ----------------------------------------------------------------
   // output data storage
   // ----------------------------------------------------------------

   // plain load, or bitwise or of the mask per pin index
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         value <= `GPSET_RST_VALUE;
      end else if (cmd.load) begin
         value <= cmd.bits;
      end else if (cmd.set) begin
         value <= value | cmd.bits;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_set_cmd;
      cmd.set && !cmd.load;
   endsequence

   a_set_forces_ones: assert property (
      @(posedge mclk) disable iff (rst)
      s_set_cmd |=> ((value & $past(cmd.bits)) == $past(cmd.bits)))
      else $error("set bit did not force output data high");

   a_zero_keeps_bit: assert property (
      @(posedge mclk) disable iff (rst)
      s_set_cmd |=> ((value & ~$past(cmd.bits)) ==
                     ($past(value) & ~$past(cmd.bits))))
      else $error("unmasked output data bit changed on set");

   a_only_same_index: assert property (
      @(posedge mclk) disable iff (rst)
      s_set_cmd |=> (value == ($past(value) | $past(cmd.bits))))
      else $error("set touched a bit of another index");

   a_idle_holds: assert property (
      @(posedge mclk) disable iff (rst)
      !cmd.set && !cmd.load |=> $stable(value))
      else $error("output data changed with no command");

endmodule

`default_nettype wire

// [src/gpset_top.sv]
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "gpset_cfg.svh"

module gpset_top (
   input wire logic mclk,
   input wire logic rst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [`GPSET_ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [`GPSET_ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic [`GPSET_DATA_W-1:0] pin_out,
   output logic [`GPSET_DATA_W-1:0] pin_oe
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   function automatic gpset_pkg::gpset_sel_t decode(
      input logic [`GPSET_ADDR_W-1:0] addr
   );
      gpset_pkg::gpset_sel_t sel;
      sel = gpset_pkg::GPSET_SEL_NONE;
      case (addr[`GPSET_ADDR_W-1:2])
         `GPSET_IDX_VALUE: sel = gpset_pkg::GPSET_SEL_VALUE;
         `GPSET_IDX_SET: sel = gpset_pkg::GPSET_SEL_SET;
         `GPSET_IDX_OEN: sel = gpset_pkg::GPSET_SEL_OEN;
         `GPSET_IDX_MODE: sel = gpset_pkg::GPSET_SEL_MODE;
         default: sel = gpset_pkg::GPSET_SEL_NONE;
      endcase
      return sel;
   endfunction

   logic have_aw;
   logic have_w;
   logic [`GPSET_ADDR_W-1:0] aw_addr;
   logic [`GPSET_DATA_W-1:0] w_data;
   logic w_lane0;
   logic next_have_aw;
   logic next_have_w;
   gpset_pkg::gpset_wstate_t wstate;
   gpset_pkg::gpset_wstate_t next_wstate;
   gpset_pkg::gpset_sel_t w_sel;
   gpset_pkg::gpset_sel_t r_sel;
   gpset_pkg::gpset_dcmd_t dcmd;
   logic [`GPSET_DATA_W-1:0] value;
   logic [`GPSET_DATA_W-1:0] oen;
   logic [`GPSET_DATA_W-1:0] mode;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic do_write;
   logic wr_ok;
   logic next_rvalid;
   logic [`GPSET_DATA_W-1:0] set_since_load;

   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;
   assign w_sel = decode(aw_addr);
   assign r_sel = decode(araddr);
   assign do_write = have_aw && have_w &&
                     (wstate == gpset_pkg::GPSET_WS_COLLECT);
   assign wr_ok = do_write && w_lane0;

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------

   // next values of the holding flags and state
   always_comb begin
      next_have_aw = have_aw;
      next_have_w = have_w;
      next_wstate = wstate;
      if (aw_take) begin
         next_have_aw = 1'b1;
      end else if (do_write) begin
         next_have_aw = 1'b0;
      end
      if (w_take) begin
         next_have_w = 1'b1;
      end else if (do_write) begin
         next_have_w = 1'b0;
      end
      case (wstate)
         gpset_pkg::GPSET_WS_COLLECT: begin
            if (do_write) begin
               next_wstate = gpset_pkg::GPSET_WS_RESP;
            end
         end
         gpset_pkg::GPSET_WS_RESP: begin
            if (bvalid && bready) begin
               next_wstate = gpset_pkg::GPSET_WS_COLLECT;
            end
         end
         default: next_wstate = gpset_pkg::GPSET_WS_COLLECT;
      endcase
   end

   // address and data capture, either order
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         have_aw <= 1'b0;
         have_w <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_lane0 <= 1'b0;
         wstate <= gpset_pkg::GPSET_WS_COLLECT;
      end else begin
         have_aw <= next_have_aw;
         have_w <= next_have_w;
         wstate <= next_wstate;
         if (aw_take) begin
            aw_addr <= awaddr;
         end
         if (w_take) begin
            w_data <= wdata[`GPSET_DATA_W-1:0];
            w_lane0 <= wstrb[0];
         end
      end
   end

   // ready and response flags
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `GPSET_RESP_OKAY;
      end else begin
         awready <= !next_have_aw &&
                    (next_wstate == gpset_pkg::GPSET_WS_COLLECT);
         wready <= !next_have_w &&
                   (next_wstate == gpset_pkg::GPSET_WS_COLLECT);
         bvalid <= (next_wstate == gpset_pkg::GPSET_WS_RESP);
         if (do_write) begin
            bresp <= (w_sel == gpset_pkg::GPSET_SEL_NONE) ?
                     `GPSET_RESP_SLVERR : `GPSET_RESP_OKAY;
         end
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------

   // command into output data, applied at the accepting edge
   always_comb begin
      dcmd.load = wr_ok && (w_sel == gpset_pkg::GPSET_SEL_VALUE);
      dcmd.set = wr_ok && (w_sel == gpset_pkg::GPSET_SEL_SET);
      dcmd.bits = w_data;
   end

   gpset_datareg gpset_datareg_i (
      .mclk(mclk),
      .rst(rst),
      .cmd(dcmd),
      .value(value)
   );

   // driver enable and pin mode
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         oen <= `GPSET_RST_OEN;
         mode <= `GPSET_RST_MODE;
      end else begin
         if (wr_ok && (w_sel == gpset_pkg::GPSET_SEL_OEN)) begin
            oen <= w_data;
         end
         if (wr_ok && (w_sel == gpset_pkg::GPSET_SEL_MODE)) begin
            mode <= w_data;
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_comb begin
      next_rvalid = rvalid;
      if (ar_take) begin
         next_rvalid = 1'b1;
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   // one read at a time, data registered on acceptance
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `GPSET_RESP_OKAY;
      end else begin
         arready <= !next_rvalid;
         rvalid <= next_rvalid;
         if (ar_take) begin
            rresp <= `GPSET_RESP_OKAY;
            case (r_sel)
               gpset_pkg::GPSET_SEL_VALUE: rdata <= {24'h0, value};
               gpset_pkg::GPSET_SEL_SET: rdata <= {24'h0, value};
               gpset_pkg::GPSET_SEL_OEN: rdata <= {24'h0, oen};
               gpset_pkg::GPSET_SEL_MODE: rdata <= {24'h0, mode};
               default: begin
                  rdata <= 32'h0;
                  rresp <= `GPSET_RESP_SLVERR;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // pins
   // ----------------------------------------------------------------

   // driver on only in gpio mode with output enabled
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_out <= `GPSET_RST_VALUE;
         pin_oe <= `GPSET_RST_OEN & `GPSET_RST_MODE;
      end else begin
         pin_out <= value;
         pin_oe <= oen & mode;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_wr_set;
      wr_ok && (w_sel == gpset_pkg::GPSET_SEL_SET);
   endsequence

   sequence s_rd_set;
      ar_take && (r_sel == gpset_pkg::GPSET_SEL_SET);
   endsequence

   // bits set since the last plain load, for the read-back check
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         set_since_load <= `GPSET_RST_VALUE;
      end else if (dcmd.load || dcmd.set) begin
         set_since_load <= dcmd.load ? 8'h00 : (set_since_load | dcmd.bits);
      end
   end

   a_set_same_edge: assert property (
      @(posedge mclk) disable iff (rst)
      s_wr_set |=> (value == ($past(value) | $past(w_data))))
      else $error("set not applied at the accepting edge");

   a_set_zero_keeps: assert property (
      @(posedge mclk) disable iff (rst)
      s_wr_set ##0 (w_data == 8'h00) |=> $stable(value))
      else $error("all-zero set mask changed output data");

   a_read_set_live: assert property (
      @(posedge mclk) disable iff (rst)
      s_rd_set |=> rvalid && (rdata == {24'h0, $past(value)}))
      else $error("set address read did not return output data");

   a_set_then_read: assert property (
      @(posedge mclk) disable iff (rst)
      s_rd_set |=> ((rdata[7:0] & $past(set_since_load)) ==
                    $past(set_since_load)))
      else $error("read after set missed the set bits");

   a_pin_enable: assert property (
      @(posedge mclk) disable iff (rst)
      1'b1 |=> (pin_oe == ($past(oen) & $past(mode))) &&
               (pin_out == $past(value)))
      else $error("pin driver not gated by mode and enable");

   a_write_answer: assert property (
      @(posedge mclk) disable iff (rst)
      do_write || (bvalid && !bready) |=> bvalid)
      else $error("write response missing or dropped");

endmodule

`default_nettype wire

// [sim/gpio_output_bit_set_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpset_cfg.svh"

// compare, count and report in one place
`define CHECK(got, exp) begin \
   check_count++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
   end \
end

module gpio_output_bit_set_tb;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [`GPSET_ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [`GPSET_DATA_W-1:0] pin_out, pin_oe;
   int err_total = 0;
   int check_count = 0;
   localparam logic [11:0] A_VAL = {`GPSET_IDX_VALUE, 2'b00};
   localparam logic [11:0] A_SET = {`GPSET_IDX_SET, 2'b00};
   localparam logic [11:0] A_OEN = {`GPSET_IDX_OEN, 2'b00};
   localparam logic [11:0] A_MODE = {`GPSET_IDX_MODE, 2'b00};
   localparam logic [11:0] A_NONE = 12'h000;

   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   gpset_top gpset_top_i (
      .mclk(mclk), .rst(rst),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(awprot), .wvalid(wvalid), .wready(wready),
      .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .pin_out(pin_out), .pin_oe(pin_oe)
   );

   // ----------------------------------------------------------------
   // bus tasks
   // ----------------------------------------------------------------
   // address and data offered together, each released when taken
   task automatic axi_write(input logic [11:0] a, input logic [7:0] d,
                            input logic [3:0] s, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      logic b_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      b_done = 1'b0;
      @(posedge mclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      bready <= 1'b1;
      while (!b_done) begin
         @(posedge mclk);
         if (!aw_done && awready) begin
            awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (!w_done && wready) begin
            wvalid <= 1'b0;
            w_done = 1'b1;
         end
         if (bvalid) begin
            b_done = 1'b1;
         end
      end
      `CHECK(bresp, er)
      bready <= 1'b0;
   endtask

   // read one word and compare data and response
   task automatic axi_read(input logic [11:0] a, input logic [7:0] ed,
                           input logic [1:0] er);
      logic ar_done;
      logic r_done;
      ar_done = 1'b0;
      r_done = 1'b0;
      @(posedge mclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      while (!r_done) begin
         @(posedge mclk);
         if (!ar_done && arready) begin
            arvalid <= 1'b0;
            ar_done = 1'b1;
         end
         if (rvalid) begin
            r_done = 1'b1;
         end
      end
      `CHECK(rdata, {24'h000000, ed})
      `CHECK(rresp, er)
      rready <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset state of output data register and pins
   task automatic test_reset();
      `CHECK(pin_out, `GPSET_RST_VALUE)
      `CHECK(pin_oe, 8'h00)
      axi_read(A_VAL, `GPSET_RST_VALUE, `GPSET_RESP_OKAY);
      axi_read(A_SET, `GPSET_RST_VALUE, `GPSET_RESP_OKAY);
   endtask

   // one bit at a time, each read straight after its write
   task automatic test_walk();
      logic [7:0] acc;
      acc = 8'h00;
      for (int i = 0; i < 8; i++) begin
         acc = acc | (8'h01 << i);
         axi_write(A_SET, 8'h01 << i, 4'hf, `GPSET_RESP_OKAY);
         axi_read(A_SET, acc, `GPSET_RESP_OKAY);
      end
   endtask

   // zero positions keep their state, ones are forced high
   task automatic test_mask();
      axi_write(A_VAL, 8'ha5, 4'hf, `GPSET_RESP_OKAY);
      axi_write(A_SET, 8'h00, 4'hf, `GPSET_RESP_OKAY);
      axi_read(A_SET, 8'ha5, `GPSET_RESP_OKAY);
      axi_write(A_SET, 8'h50, 4'hf, `GPSET_RESP_OKAY);
      axi_read(A_VAL, 8'hf5, `GPSET_RESP_OKAY);
      axi_read(A_SET, 8'hf5, `GPSET_RESP_OKAY);
      axi_write(A_VAL, 8'h00, 4'hf, `GPSET_RESP_OKAY);
      axi_write(A_SET, 8'hff, 4'h0, `GPSET_RESP_OKAY);
      axi_read(A_SET, 8'h00, `GPSET_RESP_OKAY);
      axi_write(A_SET, 8'h81, 4'hf, `GPSET_RESP_OKAY);
      axi_read(A_SET, 8'h81, `GPSET_RESP_OKAY);
   endtask

   // pins carry data and drive only where enabled and in gpio mode
   task automatic test_pins();
      axi_write(A_OEN, 8'h0f, 4'hf, `GPSET_RESP_OKAY);
      axi_write(A_MODE, 8'h3c, 4'hf, `GPSET_RESP_OKAY);
      axi_write(A_SET, 8'h24, 4'hf, `GPSET_RESP_OKAY);
      repeat (2) @(posedge mclk);
      #1;
      `CHECK(pin_out, 8'ha5)
      `CHECK(pin_oe, 8'h0c)
      axi_read(A_OEN, 8'h0f, `GPSET_RESP_OKAY);
      axi_read(A_MODE, 8'h3c, `GPSET_RESP_OKAY);
   endtask

   // unmapped address is refused and changes nothing
   task automatic test_unmapped();
      axi_write(A_NONE, 8'hff, 4'hf, `GPSET_RESP_SLVERR);
      axi_read(A_NONE, 8'h00, `GPSET_RESP_SLVERR);
      axi_read(A_SET, 8'ha5, `GPSET_RESP_OKAY);
   endtask

   // ----------------------------------------------------------------
   // verdict and run control
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog far beyond the expected run length
   initial begin
      #50000;
      err_total++;
      $display("MISMATCH t=%0t run did not finish", $time);
      wrap_up();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      test_reset();
      test_walk();
      test_mask();
      test_pins();
      test_unmapped();
      wrap_up();
   end
endmodule

`default_nettype wire
